/* File: rtl/flr_core.sv */
// self-programming access: fuse, lock and signature readout, flash op timing
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module flr_core
    import flr_pkg::*;
#(
    parameter logic [OP_CNT_W-1:0] OP_CYCLES = OP_CNT_W'(OP_MIN_CYC),
    // arbitrary neutral identification values
    parameter logic [7:0] DEV_ID0 = 8'h5A,
    parameter logic [7:0] DEV_ID1 = 8'h01,
    parameter logic [7:0] DEV_ID2 = 8'h02,
    parameter logic [SERIAL_LEN*8-1:0] SERIAL_NUM = 80'h0102030405060708090A
) (
    // clock, reset, enable
    input  wire logic                 mclk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 por_i,
    input  wire logic                 ce_i,
    // avalon-mm slave
    input  wire logic [3:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    output logic [31:0]               avs_readdata_o,
    output logic                      avs_waitrequest_o,
    // cpu instruction side
    input  wire flr_ld_req_t          ld_req_i,
    input  wire logic                 store_i,
    input  wire logic [15:0]          store_ptr_i,
    input  wire logic [7:0]           store_data_i,
    output flr_ld_rsp_t               ld_rsp_o,
    // nonvolatile sources
    input  wire logic                 eeprom_busy_i,
    input  wire logic [7:0]           fuse_low_i,
    input  wire logic [7:0]           fuse_high_i,
    input  wire logic [2:0]           fuse_ext_i,
    input  wire logic [5:0]           lock_bits_i,
    input  wire logic [7:0]           osc_cal_i,
    // flash array side
    output flr_flash_cmd_t            flash_cmd_o,
    output logic                      flash_busy_o,
    output logic                      lock_wr_o,
    output logic [3:0]                lock_wr_data_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic       en_r;
    logic       erase_r;
    logic       write_r;
    logic       lockset_r;
    logic       reen_r;
    logic       signature_read_bit_r;
    logic       rww_busy_r;
    logic       running_r;
    logic       op_lock_r;
    logic [3:0] lock_data_r;
    logic [2:0] win_r;
    logic [7:0] rdbk_r;
    logic       wait_r;
    logic       tmr_busy;
    logic       tmr_done;
    logic [7:0] sig_row [SIG_ROW_LEN];

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic       bus_req;
    logic       bus_acc;
    logic       ctrl_wr;
    logic       ctrl_ok;
    logic       ld_ok;
    logic       st_ok;
    logic [2:0] win_lim;
    logic       timeout;
    logic [7:0] ctrl_view;
    logic [7:0] rd_byte;

    assign bus_req = avs_read_i || avs_write_i;
    assign bus_acc = bus_req && !wait_r;
    assign ctrl_wr = bus_acc && avs_write_i && (avs_address_i == ADDR_CTRL);
    // no new command while eeprom busy or one pending
    assign ctrl_ok = ctrl_wr && !eeprom_busy_i && !en_r;
    // readout window, dead while eeprom writes
    assign ld_ok = ld_req_i.valid && en_r && (lockset_r || signature_read_bit_r)
                   && (win_r < LOAD_WIN) && !eeprom_busy_i;
    assign st_ok = store_i && en_r && !running_r && !signature_read_bit_r && (win_r < STORE_WIN);
    // lock-set waits for store up to four, signature only three
    assign win_lim = signature_read_bit_r ? LOAD_WIN : STORE_WIN;
    assign timeout = en_r && !running_r && (win_r == win_lim - 3'h1) && !ld_ok && !st_ok;
    assign ctrl_view = {1'b0, rww_busy_r, signature_read_bit_r, reen_r, lockset_r, write_r, erase_r, en_r};

    // ------------------------------------------------------------------
    // signature row
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SIG_ROW_LEN; gi++) begin : g_sig
            if (gi == int'(PTR_SIG_ID0)) begin : g_id0
                assign sig_row[gi] = DEV_ID0;
            end else if (gi == int'(PTR_SIG_CAL)) begin : g_cal
                assign sig_row[gi] = osc_cal_i;
            end else if (gi == int'(PTR_SIG_ID1)) begin : g_id1
                assign sig_row[gi] = DEV_ID1;
            end else if (gi == int'(PTR_SIG_ID2)) begin : g_id2
                assign sig_row[gi] = DEV_ID2;
            end else if (gi >= int'(PTR_SER_FIRST) && gi <= int'(PTR_SER_LAST)) begin : g_ser
                // last address past the ten bytes repeats the final byte
                localparam int IDX = (gi - int'(PTR_SER_FIRST) < SERIAL_LEN)
                                     ? gi - int'(PTR_SER_FIRST) : SERIAL_LEN - 1;
                assign sig_row[gi] = SERIAL_NUM[IDX*8 +: 8];
            end else begin : g_rsv
                assign sig_row[gi] = RESERVED_BYTE;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // readout select
    // ------------------------------------------------------------------
    always_comb begin
        rd_byte = RESERVED_BYTE;
        if (signature_read_bit_r) begin
            if (ld_req_i.ptr < 16'(SIG_ROW_LEN)) begin
                rd_byte = sig_row[ld_req_i.ptr[4:0]];
            end
        end else if (ld_req_i.ptr == PTR_LOCK) begin
            // lock byte layout, raw active-low bits
            rd_byte = {2'h3, lock_bits_i};
        end else if (ld_req_i.ptr == PTR_FUSE_LOW) begin
            rd_byte = fuse_low_i;
        end else if (ld_req_i.ptr == PTR_FUSE_HIGH) begin
            rd_byte = fuse_high_i;
        end else if (ld_req_i.ptr == PTR_FUSE_EXT) begin
            rd_byte = {5'h1F, fuse_ext_i};
        end
    end

    // ------------------------------------------------------------------
    // load answer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ld_rsp_o <= '0;
            rdbk_r   <= RESERVED_BYTE;
        end else if (ce_i) begin
            ld_rsp_o.valid <= ld_req_i.valid;
            // not served: cpu takes flash contents
            ld_rsp_o.served <= ld_ok;
            ld_rsp_o.data   <= ld_ok ? rd_byte : 8'h00;
            if (ld_ok) begin
                rdbk_r <= rd_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // command bits and window
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            en_r      <= 1'b0;
            erase_r   <= 1'b0;
            write_r   <= 1'b0;
            lockset_r <= 1'b0;
            reen_r    <= 1'b0;
            signature_read_bit_r   <= 1'b0;
            running_r <= 1'b0;
            win_r     <= 3'h0;
        end else if (ce_i) begin
            if (ctrl_ok) begin
                en_r      <= avs_writedata_i[BIT_PROG_EN];
                erase_r   <= avs_writedata_i[BIT_PROG_EN] && avs_writedata_i[BIT_PG_ERASE];
                write_r   <= avs_writedata_i[BIT_PROG_EN] && avs_writedata_i[BIT_PG_WRITE];
                lockset_r <= avs_writedata_i[BIT_PROG_EN] && avs_writedata_i[BIT_LOCK_SET];
                reen_r    <= avs_writedata_i[BIT_PROG_EN] && avs_writedata_i[BIT_RWW_REEN];
                signature_read_bit_r   <= avs_writedata_i[BIT_PROG_EN] && avs_writedata_i[BIT_SIG_RD];
                win_r     <= 3'h0;
            end else if (ld_ok || timeout) begin
                // auto-clear after readout or missed window
                {en_r, erase_r, write_r, lockset_r, reen_r, signature_read_bit_r} <= '0;
            end else if (st_ok) begin
                // timed operations keep enable until done
                if (erase_r || write_r || lockset_r) begin
                    running_r <= 1'b1;
                end else begin
                    {en_r, erase_r, write_r, lockset_r, reen_r, signature_read_bit_r} <= '0;
                end
            end else if (running_r && tmr_done) begin
                running_r <= 1'b0;
                {en_r, erase_r, write_r, lockset_r, reen_r, signature_read_bit_r} <= '0;
            end else if (en_r && !running_r) begin
                win_r <= win_r + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // rww busy flag
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rww_busy_r <= 1'b0;
        end else if (ce_i) begin
            // set by erase/write, cleared only by re-enable when idle
            if (st_ok && (erase_r || write_r)) begin
                rww_busy_r <= 1'b1;
            end else if (st_ok && reen_r && !tmr_busy) begin
                rww_busy_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // flash command and lock write
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            flash_cmd_o <= '0;
        end else if (ce_i) begin
            flash_cmd_o.start <= st_ok;
            if (st_ok) begin
                // page taken from the pointer page field
                flash_cmd_o.erase   <= erase_r;
                flash_cmd_o.write   <= write_r;
                flash_cmd_o.lock_wr <= lockset_r;
                flash_cmd_o.fill    <= !(erase_r || write_r || lockset_r || reen_r);
                flash_cmd_o.page    <= store_ptr_i[PAGE_MSB:PAGE_LSB];
            end
        end
    end

    // lock write result survives system reset, like the timer
    always_ff @(posedge mclk_i) begin
        if (por_i) begin
            op_lock_r      <= 1'b0;
            lock_data_r    <= 4'hF;
            lock_wr_o      <= 1'b0;
            lock_wr_data_o <= 4'hF;
        end else if (ce_i) begin
            lock_wr_o <= 1'b0;
            if (st_ok) begin
                op_lock_r <= lockset_r;
                // boot locks can only be programmed, never erased
                lock_data_r <= lock_bits_i[5:2] & store_data_i[5:2];
            end else if (tmr_done && op_lock_r) begin
                op_lock_r      <= 1'b0;
                lock_wr_o      <= 1'b1;
                lock_wr_data_o <= lock_data_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // operation timer
    // ------------------------------------------------------------------
    // duration counted here, power-on reset only
    flr_op_timer #(
        .CYCLES (OP_CYCLES)
    ) u_timer (
        .mclk_i  (mclk_i),
        .por_i   (por_i),
        .ce_i    (ce_i),
        .start_i (st_ok && (erase_r || write_r || lockset_r)),
        .busy_o  (tmr_busy),
        .done_o  (tmr_done)
    );

    always_ff @(posedge mclk_i) begin
        if (por_i) begin
            flash_busy_o <= 1'b0;
        end else if (ce_i) begin
            flash_busy_o <= tmr_busy;
        end
    end

    // ------------------------------------------------------------------
    // avalon slave
    // ------------------------------------------------------------------
    // one wait cycle keeps read data registered
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wait_r         <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            if (bus_req && wait_r) begin
                wait_r <= 1'b0;
                if (avs_address_i == ADDR_CTRL) begin
                    avs_readdata_o <= {24'h00_0000, ctrl_view};
                end else if (avs_address_i == ADDR_RDBK) begin
                    avs_readdata_o <= {24'h00_0000, rdbk_r};
                end else begin
                    avs_readdata_o <= 32'h0000_0000;
                end
            end else begin
                wait_r <= 1'b1;
            end
        end
    end
    assign avs_waitrequest_o = wait_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i || por_i || !ce_i);

    sequence s_sig_armed;
        $rose(en_r) && signature_read_bit_r;
    endsequence
    sequence s_no_load3;
        (!ld_req_i.valid)[*3];
    endsequence

    AST_EE_BLOCK: assert property (ctrl_wr && eeprom_busy_i && !en_r |=> !en_r)
        else $error("control write accepted during eeprom write");
    AST_EE_READ: assert property (ld_req_i.valid && eeprom_busy_i |=> !ld_rsp_o.served)
        else $error("readout served during eeprom write");
    AST_LOCK_RD: assert property (ld_ok && lockset_r && ld_req_i.ptr == PTR_LOCK
        |=> ld_rsp_o.served && ld_rsp_o.data == {2'h3, $past(lock_bits_i)})
        else $error("lock byte readout wrong");
    AST_EXT_FUSE: assert property (ld_ok && lockset_r && ld_req_i.ptr == PTR_FUSE_EXT
        |=> ld_rsp_o.data[7:3] == 5'h1F)
        else $error("extended fuse upper bits not one");
    AST_SIG_TMO: assert property (s_sig_armed ##0 s_no_load3 |=> !en_r)
        else $error("signature read not cleared after window");
    AST_NORMAL_LD: assert property (ld_req_i.valid && !en_r |=> !ld_rsp_o.served)
        else $error("load served with command bits clear");
    AST_EN_HOLD: assert property (st_ok && erase_r |=> en_r [*8])
        else $error("enable dropped during erase");
    AST_RWW_HOLD: assert property (rww_busy_r && !(st_ok && reen_r) |=> rww_busy_r)
        else $error("rww busy cleared without re-enable");
    AST_RST_CLR: assert property (@(posedge mclk_i) disable iff (!ce_i)
        sys_rst_i |=> !en_r && !lockset_r && !signature_read_bit_r)
        else $error("reset did not clear command bits");

endmodule : flr_core
`default_nettype wire

/* File: rtl/flr_pkg.sv */
// constants and types shared by the fuse/lock/signature readout block
package flr_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int OP_TIME_MIN_NS = 3_700_000;
    localparam int OP_TIME_MAX_NS = 4_500_000;
    localparam int OP_MIN_CYC = (OP_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OP_MAX_CYC = OP_TIME_MAX_NS / CLK_PERIOD_NS;
    localparam int OP_CNT_W = 16;
    localparam logic [2:0] LOAD_WIN = 3'h3;
    localparam logic [2:0] STORE_WIN = 3'h4;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RDBK = 4'h4;

    // control/status bit positions
    localparam int BIT_PROG_EN = 0;
    localparam int BIT_PG_ERASE = 1;
    localparam int BIT_PG_WRITE = 2;
    localparam int BIT_LOCK_SET = 3;
    localparam int BIT_RWW_REEN = 4;
    localparam int BIT_SIG_RD = 5;
    localparam int BIT_RWW_BUSY = 6;

    // ------------------------------------------------------------------
    // readout pointer values
    // ------------------------------------------------------------------
    localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] PTR_LOCK = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
    localparam logic [15:0] PTR_SIG_ID0 = 16'h0000;
    localparam logic [15:0] PTR_SIG_CAL = 16'h0001;
    localparam logic [15:0] PTR_SIG_ID1 = 16'h0002;
    localparam logic [15:0] PTR_SIG_ID2 = 16'h0004;
    localparam logic [15:0] PTR_SER_FIRST = 16'h000E;
    localparam logic [15:0] PTR_SER_LAST = 16'h0018;
    localparam int SIG_ROW_LEN = 32;
    localparam int SERIAL_LEN = 10;
    localparam logic [7:0] RESERVED_BYTE = 8'hFF;
    localparam int PAGE_LSB = 7;
    localparam int PAGE_MSB = 13;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [15:0] ptr;
    } flr_ld_req_t;

    typedef struct packed {
        logic       valid;
        logic       served;
        logic [7:0] data;
    } flr_ld_rsp_t;

    typedef struct packed {
        logic       start;
        logic       erase;
        logic       write;
        logic       lock_wr;
        logic       fill;
        logic [6:0] page;
    } flr_flash_cmd_t;

endpackage : flr_pkg

/* File: rtl/flr_op_timer.sv */
// flash operation timer: erase, page write and lock write duration
`timescale 1ns/1ps
`default_nettype none
module flr_op_timer
    import flr_pkg::*;
#(
    parameter logic [OP_CNT_W-1:0] CYCLES = OP_CNT_W'(OP_MIN_CYC)
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic por_i,
    input  wire logic ce_i,
    // control
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    logic [OP_CNT_W-1:0] cnt_r;

    // ------------------------------------------------------------------
    // countdown
    // ------------------------------------------------------------------
    // only power-on stops it: a system reset must not abort a write
    always_ff @(posedge mclk_i) begin
        if (por_i) begin
            cnt_r  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                cnt_r  <= CYCLES - OP_CNT_W'(1);
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (cnt_r == '0) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - OP_CNT_W'(1);
                end
            end
        end
    end

endmodule : flr_op_timer
`default_nettype wire

/* File: verification/flr_cpu.sv */
// cpu partner: bus master, load and store issue
`timescale 1ns/1ps
`default_nettype none
module flr_cpu
    import flr_pkg::*;
(
    // clock and status
    input  wire logic        mclk_i,
    input  wire logic        ee_busy_i,
    // avalon master
    input  wire logic        wait_i,
    input  wire logic [31:0] rdata_i,
    output logic [3:0]       adr_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic [31:0]      wd_o,
    // load and store
    input  wire flr_ld_rsp_t rsp_i,
    output flr_ld_req_t      ld_o,
    output logic             st_o,
    output logic [15:0]      sptr_o,
    output logic [7:0]       sdat_o
);
    // --------------------------------
    // bus and instruction tasks
    // --------------------------------
    int hung = 0;
    initial begin
        {adr_o, rd_o, wr_o, wd_o} = '0;
        ld_o = '0;
        {st_o, sptr_o, sdat_o} = '0;
    end
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        // a release still pending: let an edge pass first
        if (rd_o || wr_o) @(posedge mclk_i);
        wr_o <= w;
        rd_o <= !w;
        adr_o <= a;
        wd_o <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wait_i !== 1'b0 && n < 40);
        hung += int'(n >= 40);
        q = rdata_i;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        wd_o <= ~d;
    endtask : bus
    task automatic arm(input logic [7:0] c);
        logic [31:0] q;
        for (int i = 0; i < 40 && ee_busy_i; i++) @(posedge mclk_i);
        hung += int'(ee_busy_i === 1'b1);
        bus(1'b1, ADDR_CTRL, {24'h0, c}, q);
    endtask : arm
    task automatic ld(input logic [15:0] p, output flr_ld_rsp_t r);
        ld_o <= {1'b1, p};
        @(posedge mclk_i);
        ld_o <= {1'b0, ~p};
        // answer stands in the cycle after the load edge
        @(posedge mclk_i);
        r = rsp_i;
    endtask : ld
    task automatic st(input logic [15:0] p, input logic [7:0] d);
        {st_o, sptr_o, sdat_o} <= {1'b1, p, d};
        @(posedge mclk_i);
        {st_o, sptr_o, sdat_o} <= {1'b0, ~p, ~d};
        @(posedge mclk_i);
    endtask : st
endmodule : flr_cpu
`default_nettype wire

/* File: verification/flr_core_bench.sv */
// self-checking bench for the readout block
`timescale 1ns/1ps
`default_nettype none
module flr_core_bench
    import flr_pkg::*;
;
    // --------------------------------
    // stimulus and checks
    // --------------------------------
    localparam logic [79:0] SER = 80'hA1B2C3D4E5F60718293A;
    localparam int OPC = 20;
    logic mclk_i, sys_rst_i, por_i, ee, ce;
    logic [7:0] fl, fh, cal, sd, wdt;
    logic [2:0] fx;
    logic [5:0] lk;
    logic [3:0] adr, lwd;
    logic rd, wr, wt, st, fb, lw;
    logic [31:0] wd, rdt;
    logic [15:0] sp;
    flr_ld_req_t ld;
    flr_ld_rsp_t rsp;
    flr_flash_cmd_t fc;
    int fails = 0;
    int checks = 0;
    always #50 mclk_i = ~mclk_i;
    flr_core #(.OP_CYCLES(16'(OPC)), .DEV_ID0(8'h3C), .DEV_ID1(8'h4D),
               .DEV_ID2(8'h5E), .SERIAL_NUM(SER)) flr_core_inst (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .por_i(por_i), .ce_i(ce),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_readdata_o(rdt), .avs_waitrequest_o(wt),
        .ld_req_i(ld), .store_i(st), .store_ptr_i(sp), .store_data_i(sd),
        .ld_rsp_o(rsp), .eeprom_busy_i(ee), .fuse_low_i(fl), .fuse_high_i(fh),
        .fuse_ext_i(fx), .lock_bits_i(lk), .osc_cal_i(cal), .flash_cmd_o(fc),
        .flash_busy_o(fb), .lock_wr_o(lw), .lock_wr_data_o(lwd));
    flr_cpu flr_cpu_inst (
        .mclk_i(mclk_i), .ee_busy_i(ee), .wait_i(wt), .rdata_i(rdt),
        .adr_o(adr), .rd_o(rd), .wr_o(wr), .wd_o(wd), .rsp_i(rsp),
        .ld_o(ld), .st_o(st), .sptr_o(sp), .sdat_o(sd));
    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : check
    task automatic tally_and_finish();
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // serial byte i sits at 0x0E+i, last address repeats byte 9
    function automatic logic [7:0] sig_exp(int p);
        if (p >= 14 && p <= 24) return SER[8*((p > 23) ? 9 : p - 14) +: 8];
        case (p)
            0: return 8'h3C;
            1: return cal;
            2: return 8'h4D;
            4: return 8'h5E;
            default: return 8'hFF;
        endcase
    endfunction : sig_exp
    initial begin
        flr_ld_rsp_t r;
        logic [31:0] q;
        logic [7:0] e;
        logic [6:0] pg;
        int t;
        {mclk_i, sys_rst_i, por_i, ee, ce} = 5'b01101;
        {fl, fh, cal, fx, lk} = '0;
        void'($urandom(7812));
        repeat (6) @(posedge mclk_i);
        {sys_rst_i, por_i} <= 2'b00;
        {fl, fh, cal} <= 24'($urandom);
        {fx, lk, wdt} <= 17'($urandom);
        flr_cpu_inst.bus(1'b0, ADDR_CTRL, 32'h0, q);
        check("rst", q, 32'h0);
        for (int p = 0; p < 4; p++) begin
            {fl, fh, fx, lk} <= 25'($urandom);
            flr_cpu_inst.arm(8'h09);
            flr_cpu_inst.ld(16'(p), r);
            e = p == 0 ? fl : p == 1 ? {2'b11, lk} : p == 2 ? {5'h1F, fx} : fh;
            check("fuse", {r.served, r.data}, {1'b1, e});
        end
        for (int p = 0; p < 26; p++) begin
            cal <= 8'($urandom);
            flr_cpu_inst.arm(8'h21);
            flr_cpu_inst.ld(16'(p), r);
            check("sig", {r.served, r.data}, {1'b1, sig_exp(p)});
        end
        // frozen clock enable keeps the window open
        flr_cpu_inst.arm(8'h21);
        ce <= 1'b0;
        repeat (5) @(posedge mclk_i);
        ce <= 1'b1;
        flr_cpu_inst.ld(16'h0000, r);
        check("ce", {r.served, r.data}, {1'b1, sig_exp(0)});
        for (int k = 0; k < 4; k++) begin
            flr_cpu_inst.arm(k[0] ? 8'h21 : 8'h09);
            repeat (k[1] ? 3 : 2) @(posedge mclk_i);
            flr_cpu_inst.ld(16'h0001, r);
            check("late", r.served, {31'h0, !k[1]});
            flr_cpu_inst.bus(1'b0, ADDR_CTRL, 32'h0, q);
            check("clr", q, 32'h0);
        end
        ee <= 1'b1;
        flr_cpu_inst.bus(1'b1, ADDR_CTRL, 32'h09, q);
        flr_cpu_inst.bus(1'b0, ADDR_CTRL, 32'h0, q);
        check("eecmd", q, 32'h0);
        ee <= 1'b0;
        flr_cpu_inst.arm(8'h09);
        ee <= 1'b1;
        flr_cpu_inst.ld(16'h0001, r);
        check("eeld", r.served, 32'h0);
        ee <= 1'b0;
        repeat (4) @(posedge mclk_i);
        pg = 7'($urandom);
        flr_cpu_inst.arm(8'h03);
        flr_cpu_inst.st({2'b00, pg, 7'h00}, 8'hFF);
        check("ers", {fc.start, fc.erase, fc.page}, {2'b11, pg});
        t = 0;
        do begin
            flr_cpu_inst.bus(1'b0, ADDR_CTRL, 32'h0, q);
            if (t == 0) check("run", {q[BIT_RWW_BUSY], q[BIT_PROG_EN]}, 2'b11);
            t += 3;
        end while (q[BIT_PROG_EN] === 1'b1 && t < 200);
        check("dur", t >= OPC && t <= OPC + 10, 32'h1);
        check("rwwb", q[BIT_RWW_BUSY], 32'h1);
        flr_cpu_inst.arm(8'h11);
        flr_cpu_inst.st(16'h0000, 8'hFF);
        flr_cpu_inst.bus(1'b0, ADDR_CTRL, 32'h0, q);
        check("rwwc", q[BIT_RWW_BUSY], 32'h0);
        flr_cpu_inst.arm(8'h09);
        flr_cpu_inst.st(16'h0001, wdt);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        check("fbsy", fb, 32'h1);
        flr_cpu_inst.bus(1'b0, ADDR_CTRL, 32'h0, q);
        check("rst2", q, 32'h0);
        for (t = 0; t < 60 && lw !== 1'b1; t++) @(posedge mclk_i);
        check("lkw", {t < 60, lwd}, {1'b1, lk[5:2] & wdt[5:2]});
        check("hang", flr_cpu_inst.hung, 32'h0);
        tally_and_finish();
    end
endmodule : flr_core_bench
`default_nettype wire
